// ===== design/aux_timer_pkg.sv
// constants shared by the auxiliary timer pair
// Summary of operation
// R1 - with remote select clear, own run bit starts and stops each timer
// R2 - with remote select set, core run bit starts and stops the timer
// R3 - gated mode counts only while run is set and gate active
// R4 - mode codes 010/011 are gated; mode bit 0 picks gate level
// R5 - gate input changes never raise the timer flag
// R6 - mode 001 counts chosen edges of count input or toggle latch
// R7 - only hardware toggle latch changes clock the timer
// R8 - both latch edges give one step per core wrap: 32 bits
// R9 - one latch edge gives one step per two wraps: 33 bits
// R10 - chained timers keep independent count directions
// R11 - mode 101 copies core count into the timer on input edge, flag set
// R12 - software keeps input select bit 2 zero in capture mode
// R13 - capture and reload modes never count, whatever the run bit
// R14 - modes 110/111 count encoder transitions on one or both inputs
// R15 - mode 100 loads core timer from aux register on trigger, flag set
// R16 - latch triggered reload also sets the core flag
// R17 - both latch edges reload every wrap, one edge every second wrap
// R18 - same trigger on both timers: second timer wins, first ignored
// R19 - software latch writes never cause a core reload
// R20 - count registers show the count and accept writes
// R21 - direction from software bit or external direction input
// R22 - mode 000 counts the prescaled module clock
// R23 - encoder 110 flags direction changes, 111 flags every count edge
// R24 - inputs sampled on the basic clock; edge when two samples differ
// R25 - wrap up from all ones or down from zero sets the flag; encoder modes flag only their R23 events
// R26 - input select encoding is provisional
package aux_timer_pkg;
  localparam logic [7:0] OFS_A_CTRL = 8'h00;
  localparam logic [7:0] OFS_B_CTRL = 8'h04;
  localparam logic [7:0] OFS_A_CNT = 8'h08;
  localparam logic [7:0] OFS_B_CNT = 8'h0C;
  localparam logic [7:0] OFS_FLAGS = 8'h10;
  localparam logic [7:0] OFS_GROUP = 8'h14;
  // control field positions
  localparam int SEL_LSB = 0;
  localparam int MODE_LSB = 3;
  localparam int RUN_BIT = 6;
  localparam int DIR_SW_BIT = 7;
  localparam int DIR_EXT_BIT = 8;
  localparam int REMOTE_BIT = 9;
  localparam int RDIR_BIT = 13;
  localparam logic [9:0] CTRL_WMASK = 10'h3FF;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [1:0] BPS_RESET = 2'h0;
  typedef enum logic [2:0] {
    MODE_TIMER = 3'h0,
    MODE_COUNTER = 3'h1,
    MODE_GATE_LO = 3'h2,
    MODE_GATE_HI = 3'h3,
    MODE_RELOAD = 3'h4,
    MODE_CAPTURE = 3'h5,
    MODE_ENC_ROT = 3'h6,
    MODE_ENC_EDGE = 3'h7
  } aux_mode_t;
  // basic clock division per block prescaler code (non-linear)
  localparam logic [5:0] BPS_DIV_00 = 6'h08;
  localparam logic [5:0] BPS_DIV_01 = 6'h04;
  localparam logic [5:0] BPS_DIV_10 = 6'h20;
  localparam logic [5:0] BPS_DIV_11 = 6'h10;
  typedef enum logic [2:0] {
    BUS_IDLE = 3'b001,
    BUS_WRESP = 3'b010,
    BUS_RDATA = 3'b100
  } bus_state_t;
endpackage

// ===== design/input_sampler.sv
// two-stage synchroniser with basic-clock sampling and edge pulses
`timescale 1ns/1ps
module input_sampler (
  input wire logic mclk, // module clock
  input wire logic nrst, // synchronous reset, active low
  input wire logic pinIn, // asynchronous pin level
  input wire logic sampleEn, // basic clock sampling strobe
  output logic lvl, // sampled level
  output logic rise, // one-cycle pulse on rising sample pair
  output logic fall // one-cycle pulse on falling sample pair
);
  logic syncAFf;
  logic syncBFf;
  logic curFf;
  logic riseFf;
  logic fallFf;

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      syncAFf <= 1'b0;
      syncBFf <= 1'b0;
    end else begin
      syncAFf <= pinIn;
      syncBFf <= syncAFf;
    end
  end

  // edge only when two successive basic-clock samples differ
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      curFf <= 1'b0;
      riseFf <= 1'b0;
      fallFf <= 1'b0;
    end else begin
      riseFf <= sampleEn & syncBFf & ~curFf; // R24
      fallFf <= sampleEn & ~syncBFf & curFf; // R24
      if (sampleEn) begin
        curFf <= syncBFf;
      end
    end
  end

  assign lvl = curFf;
  assign rise = riseFf;
  assign fall = fallFf;
endmodule

// ===== design/aux_timer_pair.sv
// two auxiliary timers beside a core timer, with an AXI4-Lite register slave
//
// Register access over AXI4-Lite and the address map were chosen for this implementation.
`timescale 1ns/1ps
module aux_timer_pair (
  input wire logic mclk, // module clock, 250 MHz
  input wire logic nrst, // synchronous reset, active low
  input wire logic [7:0] awaddr, // write address
  input wire logic awvalid, // write address valid
  output logic awready, // write address ready
  input wire logic [31:0] wdata, // write data
  input wire logic [3:0] wstrb, // write byte enables
  input wire logic wvalid, // write data valid
  output logic wready, // write data ready
  output logic [1:0] bresp, // write response
  output logic bvalid, // write response valid
  input wire logic bready, // write response ready
  input wire logic [7:0] araddr, // read address
  input wire logic arvalid, // read address valid
  output logic arready, // read address ready
  output logic [31:0] rdata, // read data
  output logic [1:0] rresp, // read response
  output logic rvalid, // read data valid
  input wire logic rready, // read data ready
  input wire logic [1:0] auxCountIn, // count/gate/capture pins, b then a
  input wire logic [1:0] auxDirIn, // direction/encoder pins, b then a
  input wire logic [15:0] coreCount, // current core timer value
  input wire logic coreRunBit, // core run bit
  input wire logic coreToggleHw, // core toggle latch, hardware-changed copy
  output logic coreLoad, // one-cycle core reload strobe
  output logic [15:0] coreLoadValue, // value to load into the core timer
  output logic coreIrqSet, // one-cycle pulse setting the core flag
  output logic [1:0] auxIrqFlag // sticky flags, b then a
);
  localparam int NCH = 2;

  aux_timer_pkg::bus_state_t busStateFf;
  logic [15:0] ctrlFf [NCH];
  logic [1:0] flagsFf;
  logic [1:0] bpsFf;
  logic [31:0] rdataFf;
  logic [1:0] rrespFf;
  logic [1:0] brespFf;
  logic [4:0] basicCntFf;
  logic [7:0] preCntFf;
  logic tglPrevFf;
  logic coreLoadFf;
  logic [15:0] coreLoadValueFf;
  logic coreIrqSetFf;
  logic basicTick;
  logic [4:0] basicLast;
  logic tglRise;
  logic tglFall;
  logic wrTake;
  logic rdTake;
  logic [1:0] inLvl, inRise, inFall;
  logic [1:0] dLvl, dRise, dFall;
  logic [1:0] wrCnt;
  logic [1:0] irqSet;
  logic [1:0] reloadTrig;
  logic [1:0] reloadFromTgl;
  logic [31:0] cntAll;
  logic [1:0] rdirAll;
  logic [31:0] ctrlWrA;
  logic [31:0] ctrlWrB;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic known(input logic [7:0] a);
    return (a == aux_timer_pkg::OFS_A_CTRL) || (a == aux_timer_pkg::OFS_B_CTRL) ||
           (a == aux_timer_pkg::OFS_A_CNT) || (a == aux_timer_pkg::OFS_B_CNT) ||
           (a == aux_timer_pkg::OFS_FLAGS) || (a == aux_timer_pkg::OFS_GROUP);
  endfunction

  // step on the selected edges: bit0 rising, bit1 falling
  function automatic logic edgePick(input logic [1:0] sel, input logic r, input logic f);
    return (sel[0] & r) | (sel[1] & f);
  endfunction

  // ---------------- bus slave ----------------
  // write waits until address and data are both offered, then takes them together
  assign wrTake = (busStateFf == aux_timer_pkg::BUS_IDLE) & awvalid & wvalid;
  assign rdTake = (busStateFf == aux_timer_pkg::BUS_IDLE) & arvalid & ~wrTake;
  assign awready = wrTake;
  assign wready = wrTake;
  assign arready = rdTake;
  assign bvalid = (busStateFf == aux_timer_pkg::BUS_WRESP);
  assign rvalid = (busStateFf == aux_timer_pkg::BUS_RDATA);
  assign bresp = brespFf;
  assign rresp = rrespFf;
  assign rdata = rdataFf;

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      busStateFf <= aux_timer_pkg::BUS_IDLE;
      brespFf <= 2'h0;
    end else begin
      case (busStateFf)
        aux_timer_pkg::BUS_IDLE: begin
          if (wrTake) begin
            busStateFf <= aux_timer_pkg::BUS_WRESP;
            brespFf <= known(awaddr) ? 2'h0 : 2'h2;
          end else if (rdTake) begin
            busStateFf <= aux_timer_pkg::BUS_RDATA;
          end
        end
        aux_timer_pkg::BUS_WRESP: begin
          if (bready) begin
            busStateFf <= aux_timer_pkg::BUS_IDLE;
          end
        end
        aux_timer_pkg::BUS_RDATA: begin
          if (rready) begin
            busStateFf <= aux_timer_pkg::BUS_IDLE;
          end
        end
        default: begin
          busStateFf <= aux_timer_pkg::BUS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      rdataFf <= 32'h00000000;
      rrespFf <= 2'h0;
    end else if (rdTake) begin
      rrespFf <= known(araddr) ? 2'h0 : 2'h2;
      case (araddr)
        aux_timer_pkg::OFS_A_CTRL: rdataFf <= {16'h0000, 2'h0, rdirAll[0], 3'h0, ctrlFf[0][9:0]};
        aux_timer_pkg::OFS_B_CTRL: rdataFf <= {16'h0000, 2'h0, rdirAll[1], 3'h0, ctrlFf[1][9:0]};
        aux_timer_pkg::OFS_A_CNT: rdataFf <= {16'h0000, cntAll[15:0]}; // R20
        aux_timer_pkg::OFS_B_CNT: rdataFf <= {16'h0000, cntAll[31:16]}; // R20
        aux_timer_pkg::OFS_FLAGS: rdataFf <= {30'h00000000, flagsFf};
        aux_timer_pkg::OFS_GROUP: rdataFf <= {30'h00000000, bpsFf};
        default: rdataFf <= 32'h00000000;
      endcase
    end
  end

  // control registers; only mode, select, run, direction and remote bits are writable
  assign ctrlWrA = merge({16'h0000, ctrlFf[0]}, wdata, wstrb);
  assign ctrlWrB = merge({16'h0000, ctrlFf[1]}, wdata, wstrb);
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      ctrlFf[0] <= aux_timer_pkg::CTRL_RESET;
      ctrlFf[1] <= aux_timer_pkg::CTRL_RESET;
      bpsFf <= aux_timer_pkg::BPS_RESET;
    end else if (wrTake) begin
      if (awaddr == aux_timer_pkg::OFS_A_CTRL) begin
        ctrlFf[0] <= {6'h00, ctrlWrA[9:0] & aux_timer_pkg::CTRL_WMASK};
      end
      if (awaddr == aux_timer_pkg::OFS_B_CTRL) begin
        ctrlFf[1] <= {6'h00, ctrlWrB[9:0] & aux_timer_pkg::CTRL_WMASK};
      end
      if (awaddr == aux_timer_pkg::OFS_GROUP && wstrb[0]) begin
        bpsFf <= wdata[1:0];
      end
    end
  end

  assign wrCnt[0] = wrTake & (awaddr == aux_timer_pkg::OFS_A_CNT);
  assign wrCnt[1] = wrTake & (awaddr == aux_timer_pkg::OFS_B_CNT);

  // flags: hardware set wins over a write-one-to-clear in the same cycle
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      flagsFf <= 2'h0;
    end else begin
      for (int c = 0; c < NCH; c++) begin
        if (irqSet[c]) begin
          flagsFf[c] <= 1'b1;
        end else if (wrTake && awaddr == aux_timer_pkg::OFS_FLAGS && wstrb[0] && wdata[c]) begin
          flagsFf[c] <= 1'b0;
        end
      end
    end
  end
  assign auxIrqFlag = flagsFf;

  // ---------------- basic clock and prescaler ----------------
  always_comb begin
    case (bpsFf)
      2'h0: basicLast = 5'(aux_timer_pkg::BPS_DIV_00 - 6'h01);
      2'h1: basicLast = 5'(aux_timer_pkg::BPS_DIV_01 - 6'h01);
      2'h2: basicLast = 5'(aux_timer_pkg::BPS_DIV_10 - 6'h01);
      default: basicLast = 5'(aux_timer_pkg::BPS_DIV_11 - 6'h01);
    endcase
  end
  assign basicTick = (basicCntFf >= basicLast);

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      basicCntFf <= 5'h00;
      preCntFf <= 8'h00;
    end else begin
      basicCntFf <= basicTick ? 5'h00 : basicCntFf + 5'h01;
      if (basicTick) begin
        preCntFf <= preCntFf + 8'h01;
      end
    end
  end

  // toggle latch copy only moves on core wrap, so software latch writes make no edge
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      tglPrevFf <= 1'b0;
    end else begin
      tglPrevFf <= coreToggleHw;
    end
  end
  assign tglRise = coreToggleHw & ~tglPrevFf; // R7
  assign tglFall = ~coreToggleHw & tglPrevFf; // R7

  // ---------------- channels ----------------
  generate
    for (genvar i = 0; i < NCH; i++) begin : chan
      logic [15:0] cntFf;
      logic rdirFf;
      logic [15:0] ctrl;
      aux_timer_pkg::aux_mode_t mode;
      logic [2:0] isel;
      logic runSel;
      logic chanTick;
      logic gateOk;
      logic inEdge;
      logic tglEdge;
      logic trigSel;
      logic encEdgeA;
      logic encEdgeB;
      logic encDown;
      logic isEnc;
      logic dirDown;
      logic step;
      logic wrap;
      logic capTrig;
      logic chDir;
      logic [31:0] cntWr;

      input_sampler u_in (
        .mclk(mclk),
        .nrst(nrst),
        .pinIn(auxCountIn[i]),
        .sampleEn(basicTick),
        .lvl(inLvl[i]),
        .rise(inRise[i]),
        .fall(inFall[i])
      );
      input_sampler u_dir (
        .mclk(mclk),
        .nrst(nrst),
        .pinIn(auxDirIn[i]),
        .sampleEn(basicTick),
        .lvl(dLvl[i]),
        .rise(dRise[i]),
        .fall(dFall[i])
      );

      assign ctrl = ctrlFf[i];
      assign mode = aux_timer_pkg::aux_mode_t'(ctrl[aux_timer_pkg::MODE_LSB +: 3]);
      assign isel = ctrl[aux_timer_pkg::SEL_LSB +: 3];
      assign runSel = ctrl[aux_timer_pkg::REMOTE_BIT] ? coreRunBit : ctrl[aux_timer_pkg::RUN_BIT]; // R1 R2
      // timer modes reuse the select field as prescaler exponent
      assign chanTick = basicTick & ((preCntFf & 8'((9'h001 << isel) - 9'h001)) == 8'h00); // R22
      assign gateOk = mode[0] ? inLvl[i] : ~inLvl[i]; // R4
      assign inEdge = edgePick(isel[1:0], inRise[i], inFall[i]); // R26
      assign tglEdge = edgePick(isel[1:0], tglRise, tglFall); // R8 R9 R17
      assign trigSel = isel[2] ? tglEdge : inEdge; // R6 R26
      assign encEdgeA = isel[0] & (inRise[i] | inFall[i]); // R14
      assign encEdgeB = isel[1] & (dRise[i] | dFall[i]); // R14
      // quadrature direction from the new level of the moved input against the other
      assign encDown = encEdgeA ? (inLvl[i] == dLvl[i]) : (inLvl[i] != dLvl[i]);
      assign isEnc = (mode == aux_timer_pkg::MODE_ENC_ROT) || (mode == aux_timer_pkg::MODE_ENC_EDGE);
      assign dirDown = isEnc ? (encDown ^ ctrl[aux_timer_pkg::DIR_SW_BIT]) :
                       (ctrl[aux_timer_pkg::DIR_SW_BIT] ^ (ctrl[aux_timer_pkg::DIR_EXT_BIT] & dLvl[i])); // R21 R10

      always_comb begin
        case (mode)
          aux_timer_pkg::MODE_TIMER: step = runSel & chanTick; // R22
          aux_timer_pkg::MODE_GATE_LO: step = runSel & gateOk & chanTick; // R3
          aux_timer_pkg::MODE_GATE_HI: step = runSel & gateOk & chanTick; // R3
          aux_timer_pkg::MODE_COUNTER: step = runSel & trigSel; // R6
          aux_timer_pkg::MODE_ENC_ROT: step = runSel & (encEdgeA | encEdgeB); // R14
          aux_timer_pkg::MODE_ENC_EDGE: step = runSel & (encEdgeA | encEdgeB); // R14
          default: step = 1'b0; // R13
        endcase
      end

      assign wrap = step & (dirDown ? (cntFf == 16'h0000) : (cntFf == 16'hFFFF)); // R25
      // capture ignores select bit 2, which software keeps clear
      assign capTrig = (mode == aux_timer_pkg::MODE_CAPTURE) & inEdge; // R11 R12
      assign reloadTrig[i] = (mode == aux_timer_pkg::MODE_RELOAD) & trigSel; // R15 R19
      assign reloadFromTgl[i] = isel[2];
      assign chDir = (mode == aux_timer_pkg::MODE_ENC_ROT) & step & (encDown != rdirFf); // R23

      // gate level changes are not events here, only wraps, triggers and encoder steps
      assign irqSet[i] = capTrig | (reloadTrig[i] & (i == 1 || !reloadTrig[1])) | (!isEnc & wrap) |
                         chDir | ((mode == aux_timer_pkg::MODE_ENC_EDGE) & step); // R5 R11 R15 R18 R23 R25

      assign cntWr = merge({16'h0000, cntFf}, wdata, wstrb);
      always_ff @(posedge mclk) begin
        if (!nrst) begin
          cntFf <= aux_timer_pkg::CNT_RESET;
        end else if (wrCnt[i]) begin
          cntFf <= cntWr[15:0]; // R20
        end else if (capTrig) begin
          cntFf <= coreCount; // R11
        end else if (step) begin
          cntFf <= dirDown ? cntFf - 16'h0001 : cntFf + 16'h0001;
        end
      end

      always_ff @(posedge mclk) begin
        if (!nrst) begin
          rdirFf <= 1'b0;
        end else if (isEnc && step) begin
          rdirFf <= encDown;
        end
      end

      assign cntAll[i*16 +: 16] = cntFf;
      assign rdirAll[i] = rdirFf;
    end
  endgenerate

  // ---------------- core reload ----------------
  // coincident triggers: second timer's value goes to the core, first one dropped
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      coreLoadFf <= 1'b0;
      coreLoadValueFf <= 16'h0000;
      coreIrqSetFf <= 1'b0;
    end else begin
      coreLoadFf <= |reloadTrig; // R15 R17
      if (reloadTrig[1]) begin
        coreLoadValueFf <= cntAll[31:16]; // R18
      end else if (reloadTrig[0]) begin
        coreLoadValueFf <= cntAll[15:0];
      end
      coreIrqSetFf <= (reloadTrig[1] & reloadFromTgl[1]) | (reloadTrig[0] & ~reloadTrig[1] & reloadFromTgl[0]); // R16
    end
  end

  assign coreLoad = coreLoadFf;
  assign coreLoadValue = coreLoadValueFf;
  assign coreIrqSet = coreIrqSetFf;
endmodule

// ===== verification/aux_timer_pair_props.sv
// port assertions for the auxiliary timer pair
`timescale 1ns/1ps
module aux_timer_pair_props (
  input wire logic mclk, // clock
  input wire logic nrst, // reset, active low
  input wire logic [7:0] awaddr, // write address
  input wire logic awvalid, // aw valid
  input wire logic awready, // aw ready
  input wire logic [31:0] wdata, // write data
  input wire logic wvalid, // w valid
  input wire logic wready, // w ready
  input wire logic [1:0] bresp, // write response
  input wire logic bvalid, // b valid
  input wire logic bready, // b ready
  input wire logic arvalid, // ar valid
  input wire logic arready, // ar ready
  input wire logic [31:0] rdata, // read data
  input wire logic rvalid, // r valid
  input wire logic rready, // r ready
  input wire logic coreLoad, // reload strobe
  input wire logic coreIrqSet, // core flag set
  input wire logic [1:0] auxIrqFlag // sticky flags
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  a_write_answer: assert property (awvalid && awready |=> bvalid)
    else $error("write response late");
  a_read_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read data late");
  a_bresp_holds: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  a_rdata_holds: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
  a_busy_refuses: assert property (bvalid || rvalid |-> !(awready || wready || arready))
    else $error("request taken while busy");
  a_write_pairs: assert property (awready |-> awvalid && wvalid && wready)
    else $error("write half taken");
  a_core_irq_load: assert property (coreIrqSet |-> coreLoad)
    else $error("core flag without reload");
  a_load_sets_flag: assert property (coreLoad |-> ##[0:1] (auxIrqFlag != 2'h0))
    else $error("reload without timer flag");
  a_flag_sticky: assert property (auxIrqFlag[0] && !(awready && awaddr == aux_timer_pkg::OFS_FLAGS
    && wdata[0]) |=> auxIrqFlag[0])
    else $error("timer flag lost");
endmodule
bind aux_timer_pair aux_timer_pair_props aux_timer_pair_props_i (.mclk, .nrst, .awaddr, .awvalid, .awready,
  .wdata, .wvalid, .wready, .bresp, .bvalid, .bready, .arvalid, .arready, .rdata, .rvalid, .rready,
  .coreLoad, .coreIrqSet, .auxIrqFlag);

// ===== verification/core_timer_model.sv
// behavioural core timer facing the auxiliary pair
`timescale 1ns/1ps
module core_timer_model (
  input wire logic mclk, // clock
  input wire logic nrst, // reset, active low
  input wire logic run, // core run bit
  input wire logic setEn, // bench preset strobe
  input wire logic [15:0] setVal, // bench preset value
  input wire logic load, // reload strobe
  input wire logic [15:0] loadVal, // reload value
  output logic [15:0] count, // core count, always up
  output logic toggleHw // latch copy moved by wraps only
);
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      count <= 16'h0;
      toggleHw <= 1'h0;
    end else if (setEn) begin
      count <= setVal;
    end else if (load) begin
      count <= loadVal;
    end else if (run) begin
      count <= count + 16'h1;
      // no software path reaches this copy
      if (count == 16'hFFFF) toggleHw <= ~toggleHw;
    end
  end
endmodule

// ===== verification/test_aux_timer_pair.sv
// self-checking bench for the auxiliary timer pair
`timescale 1ns/1ps
module test_aux_timer_pair;
  localparam logic [7:0] ACTL = aux_timer_pkg::OFS_A_CTRL;
  localparam logic [7:0] BCTL = aux_timer_pkg::OFS_B_CTRL;
  localparam logic [7:0] ACNT = aux_timer_pkg::OFS_A_CNT;
  localparam logic [7:0] BCNT = aux_timer_pkg::OFS_B_CNT;
  localparam logic [7:0] FLG = aux_timer_pkg::OFS_FLAGS;
  logic mclk, nrst, awvalid, wvalid, bready, arvalid, rready, coreRun, setEn, loadIrq;
  logic awready, wready, bvalid, arready, rvalid, coreLoad, coreIrqSet, toggleHw;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rv;
  logic [1:0] bresp, rresp, rr, auxCountIn, dirIn, auxIrqFlag;
  logic [15:0] coreCount, setVal, loadValue, loadSeen;
  int err_total, n_compared;
  aux_timer_pair aux_timer_pair_i (.mclk, .nrst, .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hF), .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .auxCountIn, .auxDirIn(dirIn), .coreCount, .coreRunBit(coreRun), .coreToggleHw(toggleHw), .coreLoad,
    .coreLoadValue(loadValue), .coreIrqSet, .auxIrqFlag);
  core_timer_model core_timer_model_i (.mclk, .nrst, .run(coreRun), .setEn, .setVal, .load(coreLoad),
    .loadVal(loadValue), .count(coreCount), .toggleHw);
  initial begin
    mclk = 1'h0;
    forever #2 mclk = ~mclk;
  end
  always @(posedge mclk) if (coreLoad === 1'h1) begin
    loadSeen <= loadValue;
    loadIrq <= coreIrqSet;
  end
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", n, e, g);
      err_total++;
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // both halves offered together; ready is combinational, so look after settling
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    #1;
    while (awready !== 1'h1) begin @(posedge mclk); #1; end
    @(posedge mclk);
    awvalid <= 1'h0;
    wvalid <= 1'h0;
    @(posedge mclk);
    bready <= 1'h1;
    #1;
    while (bvalid !== 1'h1) begin @(posedge mclk); #1; end
    @(posedge mclk);
    bready <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'h1;
    #1;
    while (arready !== 1'h1) begin @(posedge mclk); #1; end
    @(posedge mclk);
    arvalid <= 1'h0;
    @(posedge mclk);
    rready <= 1'h1;
    #1;
    while (rvalid !== 1'h1) begin @(posedge mclk); #1; end
    d = rdata;
    r = rresp;
    @(posedge mclk);
    rready <= 1'h0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk($sformatf("reg %h", a), e, d);
  endtask
  task automatic preset(input logic [15:0] v);
    setVal <= v;
    setEn <= 1'h1;
    @(posedge mclk);
    setEn <= 1'h0;
  endtask
  task automatic spin(input logic [15:0] v);
    preset(v);
    coreRun <= 1'h1;
    wt(20);
    coreRun <= 1'h0;
  endtask
  // 40 edges hold exactly five basic ticks at the reset prescaler
  task automatic run40();
    coreRun <= 1'h1;
    wt(40);
    coreRun <= 1'h0;
  endtask
  initial begin
    {nrst, awvalid, wvalid, bready, arvalid, rready, coreRun, setEn} = 8'h0;
    {awaddr, araddr, wdata, auxCountIn, dirIn, setVal} = 68'h0;
    err_total = 0;
    n_compared = 0;
    wt(6);
    nrst <= 1'h1;
    @(posedge mclk);
    rdc(ACTL, 32'h0);
    rdc(FLG, 32'h0);
    rd(8'h20, rv, rr);
    chk("unmapped resp", 32'h2, {30'h0, rr});
    chk("unmapped data", 32'h0, rv);
    wr(ACNT, 32'h1234);
    rdc(ACNT, 32'h1234);
    wr(ACNT, 32'hFFFE);
    wr(ACTL, 32'h40);
    wt(40);
    wr(ACTL, 32'h0);
    rdc(FLG, 32'h1);
    rd(ACNT, rv, rr);
    chk("wrapped count", 32'h0, {4'h0, rv[31:4]});
    wt(40);
    rdc(ACNT, rv);
    wr(FLG, 32'h3);
    preset(16'hBEEF);
    wr(ACNT, 32'h5);
    wr(ACTL, 32'h69);
    wt(30);
    rdc(ACNT, 32'h5);
    auxCountIn[0] <= 1'h1;
    wt(30);
    rdc(ACNT, 32'hBEEF);
    rdc(FLG, 32'h1);
    wr(FLG, 32'h3);
    wr(ACNT, 32'h0);
    wr(ACTL, 32'h49);
    repeat (3) begin
      auxCountIn[0] <= 1'h0;
      wt(16);
      auxCountIn[0] <= 1'h1;
      wt(16);
    end
    wt(16);
    rdc(ACNT, 32'h3);
    for (int i = 0; i < 2; i++) begin
      wr(ACNT, 32'h0);
      wr(ACTL, i ? 32'h4D : 32'h4F);
      spin(16'hFFF8);
      spin(16'hFFF8);
      wt(4);
      rdc(ACNT, i ? 32'h1 : 32'h2);
    end
    wr(FLG, 32'h3);
    wr(ACNT, 32'h1111);
    wr(BCNT, 32'h2222);
    wr(ACTL, 32'h27);
    wr(BCTL, 32'h27);
    spin(16'hFFF8);
    wt(4);
    chk("reload value", 32'h2222, {16'h0, loadSeen});
    chk("core flag", 32'h1, {31'h0, loadIrq});
    rdc(FLG, 32'h2);
    wr(FLG, 32'h3);
    wr(ACNT, 32'h0);
    wr(ACTL, 32'h218);
    run40();
    rdc(ACNT, 32'h5);
    auxCountIn[0] <= 1'h0;
    wt(16);
    wr(ACNT, 32'h0);
    run40();
    rdc(ACNT, 32'h0);
    wr(ACTL, 32'h210);
    run40();
    rdc(ACNT, 32'h5);
    rdc(FLG, 32'h0);
    wr(ACNT, 32'h0);
    wr(ACTL, 32'h7B);
    for (int k = 0; k < 4; k++) begin
      if (k % 2 == 1) dirIn[0] <= ~dirIn[0];
      else auxCountIn[0] <= ~auxCountIn[0];
      wt(16);
    end
    rdc(ACNT, 32'h4);
    rdc(FLG, 32'h1);
    wr(FLG, 32'h3);
    wr(ACTL, 32'h73);
    dirIn[0] <= 1'h1;
    wt(16);
    rdc(ACNT, 32'h3);
    rdc(FLG, 32'h1);
    rdc(ACTL, 32'h2073);
    wr(FLG, 32'h3);
    wr(ACTL, 32'h140);
    wt(40);
    wr(ACTL, 32'h0);
    rd(ACNT, rv, rr);
    chk("down count", 32'hFFF, {20'h0, rv[15:4]});
    rdc(FLG, 32'h1);
    wrap_up();
  end
  initial begin
    wt(20000);
    err_total++;
    wrap_up();
  end
endmodule
